// ===== hw/enmac_top.sv
// Energy metering accumulator: four saturating totals fed from power samples or meter pulses,
// reported and optionally cleared at real-time-clock aligned period ends.
// Assumes a minute tick from the RTC on clk, one per minute with minute-of-hour, and a process-cycle strobe.
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - Source chosen by setting: measurement or pulses.
// - Measurement mode adds P and Q each cycle.
// - Four totals; positive to demand, negative supply.
// - Periods start at RTC multiples of period.
// - Period end reports all four totals.
// - Running totals always shown for display.
// - Pulse adds active or reactive scale setting.
// - Cumulation off clears totals after report.
// - Cumulation on keeps totals across periods.
// - Ceiling is variant factor times nominal power.
// - Nominal power is voltage times current setting.
// - Clear input or restart zeroes totals.
// - Clear input obeyed only with cumulation on.
// - Setting change clears; restart at next boundary.
// - Pulse scale 1 to 10000, default 100.
module enmac_top import enmac_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Measurement samples: signed P and Q per process cycle.
  input  wire logic        cycle_strobe,
  input  wire logic signed [31:0] p_sample,
  input  wire logic signed [31:0] q_sample,
  // RTC minute tick and minute of hour.
  input  wire logic        minute_tick,
  input  wire logic [5:0]  minute_of_hour,
  // Binary inputs.
  input  wire logic        energy_total_clear_in,
  input  wire logic        active_demand_pulse_in,
  input  wire logic        active_supply_pulse_in,
  input  wire logic        reactive_demand_pulse_in,
  input  wire logic        reactive_supply_pulse_in,
  // Display and report outputs.
  output logic [63:0]      disp_active_demand,
  output logic [63:0]      disp_active_supply,
  output logic [63:0]      disp_reactive_demand,
  output logic [63:0]      disp_reactive_supply,
  output logic             report_valid,
  output logic [63:0]      rpt_active_demand,
  output logic [63:0]      rpt_active_supply,
  output logic [63:0]      rpt_reactive_demand,
  output logic [63:0]      rpt_reactive_supply
);

  enmac_acc_if lanes[4] ();

  // Settings and state registers.
  logic [2:0]  period_ff, nxt_period;
  logic        src_pulse_ff, nxt_src_pulse;
  logic        cum_ff, nxt_cum;
  logic [1:0]  var_sel_ff, nxt_var_sel;
  logic [13:0] ascale_ff, nxt_ascale;
  logic [13:0] rscale_ff, nxt_rscale;
  logic [15:0] vnom_ff, nxt_vnom;
  logic [15:0] inom_ff, nxt_inom;
  logic        armed_ff, nxt_armed;
  logic        rdone_ff, nxt_rdone;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        rpt_ff, nxt_rpt;
  logic [63:0] rpt_ff_v [4];
  logic [63:0] nxt_rpt_v [4];
  logic        clr_meta_ff, clr_sync_ff;

  logic        setting_change, boundary, period_end, user_clear;
  logic [3:0]  rise;
  logic [31:0] factor;
  logic [31:0] pnom;
  logic [63:0] ceiling;
  logic [5:0]  per_min;
  logic [13:0] wr_a, wr_r;
  logic [63:0] tot [4];

  // Pulse inputs, each through its own synchroniser and edge detector.
  enmac_pulse_sync u_ps0 (.clk(clk), .rst_n(rst_n), .pulse_in(active_demand_pulse_in),   .rise(rise[0]));
  enmac_pulse_sync u_ps1 (.clk(clk), .rst_n(rst_n), .pulse_in(active_supply_pulse_in),   .rise(rise[1]));
  enmac_pulse_sync u_ps2 (.clk(clk), .rst_n(rst_n), .pulse_in(reactive_demand_pulse_in), .rise(rise[2]));
  enmac_pulse_sync u_ps3 (.clk(clk), .rst_n(rst_n), .pulse_in(reactive_supply_pulse_in), .rise(rise[3]));

  // The clear input is a level from outside; it is synchronised before use.
  // Two cycles of latency; a clear shorter than one clock cycle may be missed.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clr_meta_ff <= 1'b0;
      clr_sync_ff <= 1'b0;
    end else begin
      clr_meta_ff <= energy_total_clear_in;
      clr_sync_ff <= clr_meta_ff;
    end
  end

  // Ceiling: variant factor times nominal primary power.
  // Both products are formed at full width, so the ceiling cannot wrap for any legal setting.
  // A ceiling of zero (V or I written as zero) pins every total at zero until the next setting.
  always_comb begin
    case (var_sel_ff)
      2'h1:    factor = FACTOR_VAR1;
      2'h2:    factor = FACTOR_VAR2;
      default: factor = FACTOR_VAR0;
    endcase
  end
  assign pnom    = 32'(vnom_ff) * 32'(inom_ff);
  assign ceiling = 64'(factor) * 64'(pnom);

  // Period length in minutes; boundaries fall where minute-of-hour is a multiple of it.
  always_comb begin
    case (period_ff)
      ENMAC_PER_5:  per_min = 6'd5;
      ENMAC_PER_10: per_min = 6'd10;
      ENMAC_PER_15: per_min = 6'd15;
      ENMAC_PER_30: per_min = 6'd30;
      ENMAC_PER_60: per_min = 6'd60;
      default:      per_min = 6'd0;
    endcase
  end
  // The non-zero test keeps the modulo away from a zero divisor when the period is off.
  assign boundary   = minute_tick && (per_min != 6'd0) && ((minute_of_hour % per_min) == 6'd0);
  // The first boundary after a setting change only starts a period; it reports nothing.
  assign period_end = boundary && armed_ff;

  // The clear input only counts while cumulation is on.
  assign user_clear = clr_sync_ff && cum_ff;

  // Lane drive: source select, sign split, pulse scaling and clears.
  // A zero sample adds nothing and is kept out of both lanes.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    logic        meas_pos;
    logic [31:0] meas_mag;
    logic signed [31:0] smp;
    assign smp      = (i < 2) ? p_sample : q_sample;
    assign meas_pos = (i % 2) == 0;
    assign meas_mag = smp[31] ? 32'(-smp) : 32'(smp);
    always_comb begin
      if (src_pulse_ff) begin
        lanes[i].add_en  = rise[i];
        lanes[i].add_val = (i < 2) ? {18'h0, ascale_ff} : {18'h0, rscale_ff};
      end else begin
        // Positive samples feed demand lanes, negative ones supply lanes.
        lanes[i].add_en  = cycle_strobe && (smp != 32'sh0) && (meas_pos ? !smp[31] : smp[31]);
        lanes[i].add_val = meas_mag;
      end
    end
    // Clear after report only without cumulation; settings or user clear always.
    assign lanes[i].clear   = setting_change || user_clear || (period_end && !cum_ff);
    assign lanes[i].ceiling = ceiling;
    // Plain copy of the total, so the read mux can index it with a run-time address.
    assign tot[i]           = lanes[i].total;
    enmac_lane u_lane (.clk(clk), .rst_n(rst_n), .acc(lanes[i]));
  end

  // Report snapshot: the totals before the clear that follows in the same edge.
  // The snapshot stands until the next report, so a slow reader still sees a whole set.
  always_comb begin
    nxt_rpt = period_end;
    for (int i = 0; i < 4; i++)
      nxt_rpt_v[i] = rpt_ff_v[i];
    if (period_end) begin
      nxt_rpt_v[0] = lanes[0].total;
      nxt_rpt_v[1] = lanes[1].total;
      nxt_rpt_v[2] = lanes[2].total;
      nxt_rpt_v[3] = lanes[3].total;
    end
  end

  // Pulse-scale writes are clamped to the legal 1..10000 range.
  assign wr_a = (avs_writedata[13:0] < SCALE_MIN) ? SCALE_MIN :
                (avs_writedata[13:0] > SCALE_MAX) ? SCALE_MAX : avs_writedata[13:0];
  assign wr_r = (avs_writedata[29:16] < SCALE_MIN) ? SCALE_MIN :
                (avs_writedata[29:16] > SCALE_MAX) ? SCALE_MAX : avs_writedata[29:16];

  // Register slave: one wait cycle, answer on the second edge of the request.
  // Reads are looked up at the first edge so that the data stand in a register at the answering edge.
  // Writes take effect only at the answering edge, where the master sees waitrequest low; a request
  // that is withdrawn early therefore changes nothing.
  // Word map: 0 control, 1 pulse scales, 2 nominal V and I, 3 factor, 4 status, 8..15 totals.
  always_comb begin
    nxt_period    = period_ff;
    nxt_src_pulse = src_pulse_ff;
    nxt_cum       = cum_ff;
    nxt_var_sel   = var_sel_ff;
    nxt_ascale    = ascale_ff;
    nxt_rscale    = rscale_ff;
    nxt_vnom      = vnom_ff;
    nxt_inom      = inom_ff;
    nxt_rdone     = (avs_read || avs_write) && !rdone_ff;
    nxt_rdata     = rdata_ff;
    setting_change = 1'b0;
    if (avs_write && rdone_ff && avs_byteenable == 4'hf) begin
      case (avs_address[5:2])
        REG_CTRL: begin
          nxt_period    = (avs_writedata[2:0] > 3'h5) ? period_ff : avs_writedata[2:0];
          nxt_src_pulse = avs_writedata[CTRL_SRC_BIT];
          nxt_cum       = avs_writedata[CTRL_CUM_BIT];
          nxt_var_sel   = (avs_writedata[9:8] == 2'h3) ? var_sel_ff : avs_writedata[9:8];
          setting_change = 1'b1;
        end
        REG_SCALE: begin
          nxt_ascale = wr_a;
          nxt_rscale = wr_r;
          setting_change = 1'b1;
        end
        REG_NOMINAL: begin
          nxt_vnom = avs_writedata[15:0];
          nxt_inom = avs_writedata[31:16];
          setting_change = 1'b1;
        end
        default: ;
      endcase
    end
    if (avs_read && !rdone_ff) begin
      case (avs_address[5:2])
        REG_CTRL:         nxt_rdata = {22'h0, var_sel_ff, 2'h0, cum_ff, src_pulse_ff, 1'b0, period_ff};
        REG_SCALE:        nxt_rdata = {2'h0, rscale_ff, 2'h0, ascale_ff};
        REG_NOMINAL:      nxt_rdata = {inom_ff, vnom_ff};
        REG_FACTOR:       nxt_rdata = factor;
        REG_STATUS:       nxt_rdata = {30'h0, rpt_ff, armed_ff};
        default:          nxt_rdata = 32'h0;
      endcase
      if (avs_address[5] == 1'b1) begin
        // Word 8 + 2i holds the low half of total i, word 9 + 2i the high half.
        case (avs_address[4:2])
          3'h0:    nxt_rdata = tot[0][31:0];
          3'h1:    nxt_rdata = tot[0][63:32];
          3'h2:    nxt_rdata = tot[1][31:0];
          3'h3:    nxt_rdata = tot[1][63:32];
          3'h4:    nxt_rdata = tot[2][31:0];
          3'h5:    nxt_rdata = tot[2][63:32];
          3'h6:    nxt_rdata = tot[3][31:0];
          default: nxt_rdata = tot[3][63:32];
        endcase
      end
    end
    // Armed after the first boundary following a setting change.
    nxt_armed = setting_change ? 1'b0 : (boundary ? 1'b1 : armed_ff);
  end

  // Registers; restart returns every setting to its default.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_ff    <= PERIOD_RST;
      src_pulse_ff <= 1'b0;
      cum_ff       <= 1'b0;
      var_sel_ff   <= 2'h0;
      ascale_ff    <= SCALE_RST;
      rscale_ff    <= SCALE_RST;
      vnom_ff      <= NOMINAL_RST;
      inom_ff      <= NOMINAL_RST;
      armed_ff     <= 1'b0;
      rdone_ff     <= 1'b0;
      rdata_ff     <= 32'h0;
      rpt_ff       <= 1'b0;
      for (int i = 0; i < 4; i++)
        rpt_ff_v[i] <= 64'h0;
    end else begin
      period_ff    <= nxt_period;
      src_pulse_ff <= nxt_src_pulse;
      cum_ff       <= nxt_cum;
      var_sel_ff   <= nxt_var_sel;
      ascale_ff    <= nxt_ascale;
      rscale_ff    <= nxt_rscale;
      vnom_ff      <= nxt_vnom;
      inom_ff      <= nxt_inom;
      armed_ff     <= nxt_armed;
      rdone_ff     <= nxt_rdone;
      rdata_ff     <= nxt_rdata;
      rpt_ff       <= nxt_rpt;
      for (int i = 0; i < 4; i++)
        rpt_ff_v[i] <= nxt_rpt_v[i];
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !rdone_ff;
  assign avs_readdata    = rdata_ff;

  // Running totals go straight to the display.
  // Display follows each add with no wait for the period end.
  assign disp_active_demand   = lanes[0].total;
  assign disp_active_supply   = lanes[1].total;
  assign disp_reactive_demand = lanes[2].total;
  assign disp_reactive_supply = lanes[3].total;
  assign report_valid         = rpt_ff;
  assign rpt_active_demand    = rpt_ff_v[0];
  assign rpt_active_supply    = rpt_ff_v[1];
  assign rpt_reactive_demand  = rpt_ff_v[2];
  assign rpt_reactive_supply  = rpt_ff_v[3];
endmodule

// ===== include/enmac_pkg.sv
// Package for the energy metering accumulator: settings encodings, reset values, register indices.
// Assumes a single 40 MHz clock domain and a time base fed from the real-time clock.
package enmac_pkg;

  // Avalon-MM register word indices (byte address = 4 * index).
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_SCALE     = 4'h1;
  localparam logic [3:0] REG_NOMINAL   = 4'h2;
  localparam logic [3:0] REG_FACTOR    = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_ACC_BASE  = 4'h8;
  localparam logic [3:0] REG_RPT_BASE  = 4'hc;

  // Control word field positions.
  localparam int CTRL_PERIOD_LSB = 0;
  localparam int CTRL_SRC_BIT    = 4;
  localparam int CTRL_CUM_BIT    = 5;
  localparam int CTRL_SEL_LSB    = 8;

  // Period setting encodings.
  typedef enum logic [2:0] {
    ENMAC_PER_OFF, ENMAC_PER_5, ENMAC_PER_10, ENMAC_PER_15, ENMAC_PER_30, ENMAC_PER_60
  } enmac_period_type;

  // Module variant selection for the ceiling factor.
  localparam logic [31:0] FACTOR_VAR0 = 32'h0031_bcd2;
  localparam logic [31:0] FACTOR_VAR1 = 32'h03e2_c077;
  localparam logic [31:0] FACTOR_VAR2 = 32'h007c_580e;

  // Reset values of settings.
  localparam logic [2:0]  PERIOD_RST = 3'h4;
  localparam logic [13:0] SCALE_RST  = 14'h0064;
  localparam logic [13:0] SCALE_MIN  = 14'h0001;
  localparam logic [13:0] SCALE_MAX  = 14'h2710;
  localparam logic [15:0] NOMINAL_RST = 16'h0001;

  // Accumulator width.
  localparam int ACC_W = 64;

endpackage

// ===== include/enmac_acc_if.sv
// Interface between the control core and one saturating accumulator lane.
// Assumes all signals live on the single block clock.
`timescale 1ns/100ps
interface enmac_acc_if;
  logic        add_en;
  logic [31:0] add_val;
  logic        clear;
  logic [63:0] ceiling;
  logic [63:0] total;
  modport ctrl (output add_en, output add_val, output clear, output ceiling, input total);
  modport lane (input add_en, input add_val, input clear, input ceiling, output total);
endinterface

// ===== hw/enmac_pulse_sync.sv
// Two-flop synchroniser with rising-edge detection for an external meter pulse.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module enmac_pulse_sync import enmac_pkg::*; (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pulse_in,
  output logic      rise
);
  logic meta_ff, sync_ff, last_ff;
  logic nxt_meta, nxt_sync, nxt_last;

  // Only sync_ff and last_ff are used by the edge detector, never meta_ff.
  always_comb begin
    nxt_meta = pulse_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // One pulse per rising edge, however long the input stays high.
  assign rise = sync_ff & ~last_ff;
endmodule

// ===== hw/enmac_lane.sv
// One saturating energy accumulator lane.
// Assumes the ceiling is stable between clears.
`timescale 1ns/100ps
module enmac_lane import enmac_pkg::*; (
  input  wire logic clk,
  input  wire logic rst_n,
  enmac_acc_if.lane acc
);
  logic [63:0] total_ff, nxt_total;
  logic [64:0] sum;

  // Clear has priority; a sum past the ceiling holds there instead of wrapping.
  always_comb begin
    sum       = {1'b0, total_ff} + {33'h0, acc.add_val};
    nxt_total = total_ff;
    if (acc.clear)
      nxt_total = 64'h0;
    else if (acc.add_en) begin
      if (sum > {1'b0, acc.ceiling})
        nxt_total = acc.ceiling;
      else
        nxt_total = sum[63:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      total_ff <= 64'h0;
    else
      total_ff <= nxt_total;
  end

  assign acc.total = total_ff;
endmodule

// ===== verif/enmac_meter_model.sv
// Stand-in for the external energy meter: four pulse contacts.
// Assumes the bench calls emit just after a rising edge of clk.
`timescale 1ns/100ps
module enmac_meter_model (
  input  wire logic       clk,
  output logic      [3:0] pulse
);
  // Contacts rest low between pulses, so a missed edge cannot pass as a held level.
  initial pulse = 4'h0;

  // Hold one lane high for w cycles; long pulses probe single counting.
  task automatic emit(input int lane, input int w);
    pulse[lane] <= 1'b1;
    repeat (w) @(posedge clk);
    pulse[lane] <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ===== verif/enmac_checker.sv
// Checker for the accumulator top: bus handshake and period reports.
// Assumes it is bound into enmac_top with one clock.
`timescale 1ns/100ps
module enmac_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        minute_tick,
  input wire logic [5:0]  minute_of_hour,
  input wire logic        report_valid,
  input wire logic [63:0] disp_active_demand,
  input wire logic [63:0] disp_reactive_supply,
  input wire logic [63:0] rpt_active_demand,
  input wire logic [63:0] rpt_reactive_supply
);
  // All checks share the block clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic req;
  assign req = avs_read | avs_write;

  property p_wait_first;
    req && !$past(req) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("waitrequest low in first request cycle");
  property p_wait_answer;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  property p_rpt_pulse;
    report_valid |=> !report_valid;
  endproperty
  a_rpt_pulse: assert property (p_rpt_pulse) else $error("report longer than one cycle");
  property p_rpt_tick;
    report_valid |-> $past(minute_tick);
  endproperty
  a_rpt_tick: assert property (p_rpt_tick) else $error("report without minute tick");
  property p_rpt_align;
    report_valid |-> ($past(minute_of_hour) % 5) == 0;
  endproperty
  a_rpt_align: assert property (p_rpt_align) else $error("report off boundary");
  property p_rpt_ad;
    report_valid |-> rpt_active_demand == $past(disp_active_demand);
  endproperty
  a_rpt_ad: assert property (p_rpt_ad) else $error("active demand report wrong");
  property p_rpt_rs;
    report_valid |-> rpt_reactive_supply == $past(disp_reactive_supply);
  endproperty
  a_rpt_rs: assert property (p_rpt_rs) else $error("reactive supply report wrong");
  property p_rpt_hold;
    !report_valid |-> $stable(rpt_active_demand);
  endproperty
  a_rpt_hold: assert property (p_rpt_hold) else $error("report moved between periods");
endmodule

bind enmac_top enmac_checker u_chk (.*);

// ===== verif/enmac_top_tb.sv
// Self-checking bench for the accumulator: bus, samples, minute ticks, meter pulses.
// Assumes the meter model drives the four pulse inputs.
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module enmac_top_tb;
  logic               clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic               cycle_strobe, minute_tick, energy_total_clear_in, report_valid;
  logic               active_demand_pulse_in, active_supply_pulse_in;
  logic               reactive_demand_pulse_in, reactive_supply_pulse_in;
  logic        [5:0]  avs_address, minute_of_hour;
  logic        [3:0]  avs_byteenable, pulse;
  logic        [31:0] avs_writedata, avs_readdata, q;
  logic signed [31:0] p_sample, q_sample;
  logic        [63:0] disp_active_demand, disp_active_supply, disp_reactive_demand, disp_reactive_supply;
  logic        [63:0] rpt_active_demand, rpt_active_supply, rpt_reactive_demand, rpt_reactive_supply;
  logic        [31:0] fac [4] = '{32'h0031_bcd2, 32'h03e2_c077, 32'h007c_580e, 32'h007c_580e};
  int                 err_total, checks, seen;

  enmac_top u_dut (.*);
  enmac_meter_model u_meter (.clk(clk), .pulse(pulse));
  // Lanes of the meter map onto the four binary inputs.
  assign active_demand_pulse_in   = pulse[0];
  assign active_supply_pulse_in   = pulse[1];
  assign reactive_demand_pulse_in = pulse[2];
  assign reactive_supply_pulse_in = pulse[3];

  // 40 MHz block clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Print counts, then the verdict, and stop.
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One bus transfer; the request stands until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int   n;
    logic w;
    n = 0;
    w = 1'b1;
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    // Sampled as the edge arrives, before the design's registers move.
    while (w && n < 20) begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (w) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // One process-cycle sample of P and Q.
  task automatic smp(input logic signed [31:0] p, input logic signed [31:0] r);
    cycle_strobe <= 1'b1;
    p_sample <= p;
    q_sample <= r;
    @(posedge clk);
    cycle_strobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // One minute tick; counts report pulses in the following cycles.
  task automatic tick(input logic [5:0] m);
    seen = 0;
    minute_tick <= 1'b1;
    minute_of_hour <= m;
    @(posedge clk);
    minute_tick <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      if (report_valid === 1'b1) seen++;
    end
  endtask

  // Level on the clear input for a few cycles.
  task automatic clr();
    energy_total_clear_in <= 1'b1;
    repeat (6) @(posedge clk);
    energy_total_clear_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Main sequence.
  initial begin
    {rst_n, avs_read, avs_write, cycle_strobe, minute_tick, energy_total_clear_in} = 6'h00;
    avs_address = 6'h00;
    minute_of_hour = 6'h00;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    p_sample = 32'h0;
    q_sample = 32'h0;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 6'h00, 32'h0); `CHK(q, 32'h0000_0004)
    bus(1'b0, 6'h04, 32'h0); `CHK(q, 32'h0064_0064)
    bus(1'b0, 6'h0c, 32'h0); `CHK(q, fac[0])
    bus(1'b0, 6'h14, 32'h0); `CHK(q, 32'h0)
    $display("test defaults done");
    tick(6'h00);
    smp(32'sh64, -32'sh32);
    smp(-32'sh1e, 32'sh7);
    clr();
    `CHK(disp_active_demand, 64'h64)
    `CHK(disp_active_supply, 64'h1e)
    `CHK(disp_reactive_demand, 64'h7)
    `CHK(disp_reactive_supply, 64'h32)
    bus(1'b0, 6'h3c, 32'h0); `CHK(q, 32'h0)
    bus(1'b0, 6'h38, 32'h0); `CHK(q, 32'h32)
    tick(6'h0a); `CHK(seen, 0)
    tick(6'h1e); `CHK(seen, 1)
    `CHK(rpt_active_supply, 64'h1e)
    `CHK(rpt_active_demand, 64'h64)
    `CHK(rpt_reactive_demand, 64'h7)
    `CHK(rpt_reactive_supply, 64'h32)
    `CHK(disp_active_demand, 64'h0)
    $display("test measurement done");
    bus(1'b1, 6'h00, 32'h0000_0021);
    tick(6'h05);
    smp(32'sh8, 32'sh0);
    tick(6'h0a); `CHK(seen, 1)
    `CHK(rpt_active_demand, 64'h8)
    `CHK(disp_active_demand, 64'h8)
    clr(); `CHK(disp_active_demand, 64'h0)
    $display("test cumulation done");
    tick(6'h0f);
    smp(32'sh8, 32'sh0);
    bus(1'b1, 6'h00, 32'h0); `CHK(disp_active_demand, 64'h0)
    tick(6'h00);
    tick(6'h00); `CHK(seen, 0)
    $display("test period off done");
    bus(1'b1, 6'h04, 32'h2711_0000);
    bus(1'b0, 6'h04, 32'h0); `CHK(q, 32'h2710_0001)
    bus(1'b1, 6'h00, 32'h0000_0014);
    tick(6'h00);
    u_meter.emit(0, 20);
    u_meter.emit(1, 2);
    u_meter.emit(1, 2);
    u_meter.emit(2, 3);
    u_meter.emit(3, 8);
    smp(32'sh64, 32'sh64);
    repeat (6) @(posedge clk);
    `CHK(disp_active_demand, 64'h1)
    `CHK(disp_active_supply, 64'h2)
    `CHK(disp_reactive_demand, 64'h2710)
    `CHK(disp_reactive_supply, 64'h2710)
    $display("test pulses done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 6'h00, {22'h0, 2'(i), 8'h04});
      bus(1'b0, 6'h0c, 32'h0); `CHK(q, fac[i])
    end
    bus(1'b1, 6'h00, 32'h0000_0004);
    bus(1'b1, 6'h08, 32'h0003_0002);
    tick(6'h00);
    smp(32'sh7fff_ffff, 32'sh0);
    smp(32'sh7fff_ffff, 32'sh0);
    `CHK(disp_active_demand, 64'(fac[0]) * 64'h6)
    $display("test ceiling done");
    tally_and_finish();
  end
endmodule
